// [led_i2c_consts.svh]
`ifndef LED_I2C_CONSTS_SVH
`define LED_I2C_CONSTS_SVH

// Fixed upper five bits of the target address.
`define TGT_ADDR_HIGH      5'b01100
// Two low address bits for each strap connection.
`define STRAP_CODE_GND     2'b00
`define STRAP_CODE_VCC     2'b11
`define STRAP_CODE_CLK     2'b01
`define STRAP_CODE_DATA    2'b10
// Direction bit values.
`define DIR_WRITE          1'b0
`define DIR_READ           1'b1
// Reset value of the register pointer.
`define REG_PTR_RESET      8'h00
// Bus clock limit, the least divider derived from it, and the controller's default divider.
`define SYS_CLK_MHZ        100
`define BUS_CLK_MAX_KHZ    1000
`define BUS_HALF_MIN_CYC   ((`SYS_CLK_MHZ * 1000 + 2 * `BUS_CLK_MAX_KHZ - 1) \
                            / (2 * `BUS_CLK_MAX_KHZ))
`define BUS_HALF_CYC       250

`endif

// [led_i2c_pkg.sv]
package led_i2c_pkg;

    typedef enum logic [1:0] {
        STRAP_GND,
        STRAP_VCC,
        STRAP_CLK,
        STRAP_DATA
    } strap_type;

    typedef enum logic [2:0] {
        TGT_IDLE,
        TGT_ADDR,
        TGT_ACK,
        TGT_WDATA,
        TGT_RDATA,
        TGT_RACK,
        TGT_IGNORE
    } tgt_state_type;

    typedef enum logic [3:0] {
        CTL_IDLE,
        CTL_START,
        CTL_BIT_LOW,
        CTL_BIT_HIGH,
        CTL_ACK_LOW,
        CTL_ACK_HIGH,
        CTL_STOP_LOW,
        CTL_STOP_HIGH,
        CTL_STOP_END
    } ctl_state_type;

endpackage

// [led_i2c_if.sv]
`timescale 1ns/1ps
interface led_i2c_if;
    logic scl;
    logic scl_o;
    logic sda_ctl_o;
    logic sda_ctl_oe;
    logic sda_tgt_o;
    logic sda_tgt_oe;
    logic sda;

    // Clock follows the controller; data is open-drain: low when any end drives low, else pulled high.
    assign scl = scl_o;
    assign sda = !((sda_ctl_oe && !sda_ctl_o) || (sda_tgt_oe && !sda_tgt_o));

    modport target (
        input  scl,
        input  sda,
        output sda_tgt_o,
        output sda_tgt_oe
    );

    modport controller (
        input  sda,
        output scl_o,
        output sda_ctl_o,
        output sda_ctl_oe
    );
endinterface

// [led_i2c_target.sv]
`timescale 1ns/1ps
`include "led_i2c_consts.svh"

module led_i2c_target
    import led_i2c_pkg::*;
(
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    led_i2c_if.target       bus,
    input  wire strap_type  strap_i,
    input  wire logic [7:0] rd_data_i,
    output logic      [7:0] reg_ptr_o,
    output logic      [7:0] wr_data_o,
    output logic            wr_valid_o,
    output logic            busy_o
);

    // Three-stage synchronisers; the first stage feeds only the second.
    logic [2:0]    scl_sync_q, scl_sync_d;
    logic [2:0]    sda_sync_q, sda_sync_d;
    logic          scl_q, scl_d;
    logic          sda_q, sda_d;
    logic [5:0]    strap_sync_q, strap_sync_d;
    logic [1:0]    strap_q, strap_d;

    tgt_state_type state_q, state_d;
    logic [3:0]    cnt_q, cnt_d;
    logic [7:0]    shift_q, shift_d;
    logic          first_q, first_d;
    logic          is_read_q, is_read_d;
    logic [7:0]    ptr_q, ptr_d;
    logic [7:0]    wdata_q, wdata_d;
    logic          wvalid_q, wvalid_d;
    logic          oe_q, oe_d;
    logic          busy_q, busy_d;

    function automatic logic [1:0] strap_bits(input strap_type s);
        case (s)
            STRAP_GND: strap_bits = `STRAP_CODE_GND;
            STRAP_VCC: strap_bits = `STRAP_CODE_VCC;
            STRAP_CLK: strap_bits = `STRAP_CODE_CLK;
            default:   strap_bits = `STRAP_CODE_DATA;
        endcase
    endfunction

    logic [6:0] own_addr;
    logic       scl_rise, scl_fall, start_cond, stop_cond;

    always_comb begin
        // The strap is a pin, so its decoded bits pass a synchroniser too.
        strap_sync_d = {strap_sync_q[3:0], strap_bits(strap_i)};
        strap_d = (strap_sync_q[5:4] == strap_sync_q[3:2]) ? strap_sync_q[5:4]
                                                           : strap_q;
        own_addr = {`TGT_ADDR_HIGH, strap_q};
        scl_sync_d = {scl_sync_q[1:0], bus.scl};
        sda_sync_d = {sda_sync_q[1:0], bus.sda};
        scl_d = (scl_sync_q[2] == scl_sync_q[1]) ? scl_sync_q[2] : scl_q;
        sda_d = (sda_sync_q[2] == sda_sync_q[1]) ? sda_sync_q[2] : sda_q;
        scl_rise = scl_d && !scl_q;
        scl_fall = !scl_d && scl_q;
        start_cond = scl_q && scl_d && sda_q && !sda_d;
        stop_cond = scl_q && scl_d && !sda_q && sda_d;
    end

    always_comb begin
        state_d   = state_q;
        cnt_d     = cnt_q;
        shift_d   = shift_q;
        first_d   = first_q;
        is_read_d = is_read_q;
        ptr_d     = ptr_q;
        wdata_d   = wdata_q;
        wvalid_d  = 1'b0;
        oe_d      = oe_q;
        busy_d    = busy_q;
        if (start_cond) begin
            state_d = TGT_ADDR;
            cnt_d   = 4'h0;
            oe_d    = 1'b0;
            busy_d  = 1'b1;
        end else if (stop_cond) begin
            state_d = TGT_IDLE;
            oe_d    = 1'b0;
            busy_d  = 1'b0;
        end else begin
            case (state_q)
                TGT_ADDR, TGT_WDATA: begin
                    if (scl_rise) begin
                        shift_d = {shift_q[6:0], sda_d};
                        cnt_d   = cnt_q + 4'h1;
                    end else if (scl_fall && cnt_q == 4'h8) begin
                        cnt_d = 4'h0;
                        if (state_q == TGT_ADDR) begin
                            if (shift_q[7:1] == own_addr) begin
                                oe_d      = 1'b1;
                                is_read_d = (shift_q[0] == `DIR_READ);
                                first_d   = 1'b1;
                                state_d   = TGT_ACK;
                            end else begin
                                state_d = TGT_IGNORE;
                            end
                        end else begin
                            oe_d    = 1'b1;
                            state_d = TGT_ACK;
                            if (first_q) begin
                                ptr_d   = shift_q;
                                first_d = 1'b0;
                            end else begin
                                wdata_d  = shift_q;
                                wvalid_d = 1'b1;
                            end
                        end
                    end
                end
                TGT_ACK: begin
                    if (scl_fall) begin
                        cnt_d = 4'h0;
                        if (is_read_q) begin
                            shift_d = rd_data_i;
                            oe_d    = !rd_data_i[7];
                            state_d = TGT_RDATA;
                        end else begin
                            oe_d    = 1'b0;
                            state_d = TGT_WDATA;
                        end
                    end else if (wvalid_q) begin
                        ptr_d = ptr_q + 8'h01;
                    end
                end
                TGT_RDATA: begin
                    if (scl_rise) begin
                        cnt_d = cnt_q + 4'h1;
                    end else if (scl_fall) begin
                        if (cnt_q == 4'h8) begin
                            oe_d    = 1'b0;
                            state_d = TGT_RACK;
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            oe_d    = !shift_q[6];
                        end
                    end
                end
                TGT_RACK: begin
                    if (scl_rise) begin
                        if (sda_d) begin
                            state_d = TGT_IGNORE;
                        end else begin
                            ptr_d     = ptr_q + 8'h01;
                            is_read_d = 1'b1;
                            state_d   = TGT_ACK;
                        end
                    end
                end
                default: begin
                    oe_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_sync_q <= 3'b111;
            sda_sync_q <= 3'b111;
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
            strap_sync_q <= 6'h00;
            strap_q    <= `STRAP_CODE_GND;
            state_q    <= TGT_IDLE;
            cnt_q      <= 4'h0;
            shift_q    <= 8'h00;
            first_q    <= 1'b0;
            is_read_q  <= 1'b0;
            ptr_q      <= `REG_PTR_RESET;
            wdata_q    <= 8'h00;
            wvalid_q   <= 1'b0;
            oe_q       <= 1'b0;
            busy_q     <= 1'b0;
        end else begin
            scl_sync_q <= scl_sync_d;
            sda_sync_q <= sda_sync_d;
            scl_q      <= scl_d;
            sda_q      <= sda_d;
            strap_sync_q <= strap_sync_d;
            strap_q    <= strap_d;
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            shift_q    <= shift_d;
            first_q    <= first_d;
            is_read_q  <= is_read_d;
            ptr_q      <= ptr_d;
            wdata_q    <= wdata_d;
            wvalid_q   <= wvalid_d;
            oe_q       <= oe_d;
            busy_q     <= busy_d;
        end
    end

    assign bus.sda_tgt_o  = 1'b0;
    assign bus.sda_tgt_oe = oe_q;
    assign reg_ptr_o      = ptr_q;
    assign wr_data_o      = wdata_q;
    assign wr_valid_o     = wvalid_q;
    assign busy_o         = busy_q;

endmodule // led_i2c_target

// [led_i2c_controller.sv]
`timescale 1ns/1ps
`include "led_i2c_consts.svh"

module led_i2c_controller
    import led_i2c_pkg::*;
#(
    parameter int HALF_CYC = `BUS_HALF_CYC
) (
    input  wire logic       ref_clk_i,
    input  wire logic       reset_n_i,
    led_i2c_if.controller   bus,
    input  wire logic       req_i,
    input  wire logic [7:0] req_byte_i,
    input  wire logic       req_start_i,
    input  wire logic       req_stop_i,
    input  wire logic       req_read_i,
    input  wire logic       req_nack_i,
    output logic            done_o,
    output logic            ack_o,
    output logic [7:0]      rd_byte_o,
    output logic            busy_o
);

    if (HALF_CYC < `BUS_HALF_MIN_CYC || HALF_CYC > 65535) begin : g_half_chk
        $error("HALF_CYC out of range");
    end

    ctl_state_type state_q, state_d;
    logic [15:0]   tick_q, tick_d;
    logic [3:0]    bit_q, bit_d;
    logic [7:0]    shift_q, shift_d;
    logic          scl_q, scl_d;
    logic          sda_q, sda_d;
    logic          rd_q, rd_d;
    logic          nack_q, nack_d;
    logic          stop_q, stop_d;
    logic          done_q, done_d;
    logic          ack_q, ack_d;
    logic [7:0]    rbyte_q, rbyte_d;
    logic          busy_q, busy_d;
    logic [2:0]    sda_sync_q, sda_sync_d;
    logic          sda_in_q, sda_in_d;
    logic          tick_end;

    always_comb begin
        sda_sync_d = {sda_sync_q[1:0], bus.sda};
        sda_in_d   = (sda_sync_q[2] == sda_sync_q[1]) ? sda_sync_q[2]
                                                      : sda_in_q;
        tick_end   = (tick_q == 16'(HALF_CYC - 1));
        state_d = state_q;
        tick_d  = tick_end ? 16'h0000 : tick_q + 16'h0001;
        bit_d   = bit_q;
        shift_d = shift_q;
        scl_d   = scl_q;
        sda_d   = sda_q;
        rd_d    = rd_q;
        nack_d  = nack_q;
        stop_d  = stop_q;
        done_d  = 1'b0;
        ack_d   = ack_q;
        rbyte_d = rbyte_q;
        busy_d  = busy_q;
        case (state_q)
            CTL_IDLE: begin
                tick_d = 16'h0000;
                if (req_i) begin
                    shift_d = req_byte_i;
                    rd_d    = req_read_i;
                    nack_d  = req_nack_i;
                    stop_d  = req_stop_i;
                    bit_d   = 4'h0;
                    busy_d  = 1'b1;
                    state_d = req_start_i ? CTL_START : CTL_BIT_LOW;
                    if (req_start_i) begin
                        sda_d = 1'b1;
                    end
                end
            end
            CTL_START: begin
                if (tick_end) begin
                    // A repeated start keeps the clock low a full phase.
                    if (!scl_q) begin
                        scl_d = 1'b1;
                    end else if (!sda_q) begin
                        scl_d   = 1'b0;
                        state_d = CTL_BIT_LOW;
                    end else begin
                        sda_d = 1'b0;
                    end
                end
            end
            CTL_BIT_LOW: begin
                // change data only while clock low
                sda_d = rd_q ? 1'b1 : shift_q[7];
                if (tick_end) begin
                    scl_d   = 1'b1;
                    state_d = CTL_BIT_HIGH;
                end
            end
            CTL_BIT_HIGH: begin
                if (tick_end) begin
                    scl_d   = 1'b0;
                    shift_d = {shift_q[6:0], sda_in_q};
                    if (bit_q == 4'h7) begin
                        state_d = CTL_ACK_LOW;
                    end else begin
                        bit_d   = bit_q + 4'h1;
                        state_d = CTL_BIT_LOW;
                    end
                end
            end
            CTL_ACK_LOW: begin
                sda_d = rd_q ? nack_q : 1'b1;
                if (tick_end) begin
                    scl_d   = 1'b1;
                    state_d = CTL_ACK_HIGH;
                end
            end
            CTL_ACK_HIGH: begin
                if (tick_end) begin
                    scl_d   = 1'b0;
                    ack_d   = !sda_in_q;
                    rbyte_d = shift_q;
                    if (stop_q || (!rd_q && sda_in_q)) begin
                        state_d = CTL_STOP_LOW;
                    end else begin
                        done_d  = 1'b1;
                        busy_d  = 1'b0;
                        state_d = CTL_IDLE;
                    end
                end
            end
            CTL_STOP_LOW: begin
                sda_d = 1'b0;
                if (tick_end) begin
                    scl_d   = 1'b1;
                    state_d = CTL_STOP_HIGH;
                end
            end
            CTL_STOP_HIGH: begin
                if (tick_end) begin
                    sda_d   = 1'b1;
                    state_d = CTL_STOP_END;
                end
            end
            default: begin
                if (tick_end) begin
                    done_d  = 1'b1;
                    busy_d  = 1'b0;
                    state_d = CTL_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_q    <= CTL_IDLE;
            tick_q     <= 16'h0000;
            bit_q      <= 4'h0;
            shift_q    <= 8'h00;
            scl_q      <= 1'b1;
            sda_q      <= 1'b1;
            rd_q       <= 1'b0;
            nack_q     <= 1'b0;
            stop_q     <= 1'b0;
            done_q     <= 1'b0;
            ack_q      <= 1'b0;
            rbyte_q    <= 8'h00;
            busy_q     <= 1'b0;
            sda_sync_q <= 3'b111;
            sda_in_q   <= 1'b1;
        end else begin
            state_q    <= state_d;
            tick_q     <= tick_d;
            bit_q      <= bit_d;
            shift_q    <= shift_d;
            scl_q      <= scl_d;
            sda_q      <= sda_d;
            rd_q       <= rd_d;
            nack_q     <= nack_d;
            stop_q     <= stop_d;
            done_q     <= done_d;
            ack_q      <= ack_d;
            rbyte_q    <= rbyte_d;
            busy_q     <= busy_d;
            sda_sync_q <= sda_sync_d;
            sda_in_q   <= sda_in_d;
        end
    end

    // controller alone drives clock; data open-drain
    assign bus.scl_o      = scl_q;
    assign bus.sda_ctl_o  = 1'b0;
    assign bus.sda_ctl_oe = !sda_q;
    assign done_o         = done_q;
    assign ack_o          = ack_q;
    assign rd_byte_o      = rbyte_q;
    assign busy_o         = busy_q;

endmodule // led_i2c_controller

// [led_i2c_props.sv]
`timescale 1ns/1ps
module led_i2c_props #(
    parameter int MIN_HALF = 50
) (
    input  wire logic ref_clk_i,
    input  wire logic reset_n_i,
    input  wire logic scl,
    input  wire logic scl_o,
    input  wire logic sda,
    input  wire logic sda_ctl_o,
    input  wire logic sda_ctl_oe,
    input  wire logic sda_tgt_o,
    input  wire logic sda_tgt_oe
);
    logic        scl_q;
    logic        scl_d;
    logic [15:0] run_q;
    logic [15:0] run_d;

    // Counts how long the bus clock has held its present level.
    always_comb begin
        scl_d = scl;
        run_d = run_q;
        if (scl != scl_q) begin
            run_d = 16'h0000;
        end else if (run_q != 16'hffff) begin
            run_d = run_q + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_q <= 1'b1;
            run_q <= 16'hffff;
        end else begin
            scl_q <= scl_d;
            run_q <= run_d;
        end
    end

    default clocking dc @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    a_start_no_tgt: assert property (
        $fell(sda) && scl_o |-> !sda_tgt_oe)
        else $error("target pulls data at a start");
    a_tgt_open_drain: assert property (sda_tgt_oe |-> !sda_tgt_o)
        else $error("target drives data high");
    a_ctl_open_drain: assert property (sda_ctl_oe |-> !sda_ctl_o)
        else $error("controller drives data high");
    a_tgt_stable_high: assert property (
        scl && $past(scl) |-> $stable(sda_tgt_oe))
        else $error("target data changed while clock high");
    a_tgt_change_low: assert property (
        $changed(sda_tgt_oe) |-> !scl && run_q < 16'h000a)
        else $error("target data change late or while clock high");
    a_half_period: assert property (
        (scl != scl_q) |-> int'(run_q) >= MIN_HALF - 1)
        else $error("bus clock phase too short");
    a_ack_exclusive: assert property (
        sda_tgt_oe && scl |-> !sda_ctl_oe)
        else $error("controller pulls data while target answers");
    a_stop_idle: assert property (
        $rose(sda) && scl |-> (scl && sda) [*8])
        else $error("bus not idle after stop");

    c_tgt_ack: cover property (sda_tgt_oe && scl);
    c_start: cover property ($fell(sda) && scl);
    c_stop: cover property ($rose(sda) && scl);
endmodule // led_i2c_props

// [tb_top.sv]
`timescale 1ns/1ps
module tb_top
    import led_i2c_pkg::*;
;
    typedef struct packed {
        strap_type  strap;
        logic [7:0] addr;
        logic       ack;
    } row_type;

    logic       ref_clk_i = 1'b0;
    logic       reset_n_i = 1'b0;
    strap_type  strap     = STRAP_GND;
    logic       req       = 1'b0;
    logic [7:0] req_byte  = 8'h00;
    logic       req_start = 1'b0;
    logic       req_stop  = 1'b0;
    logic       req_read  = 1'b0;
    logic       req_nack  = 1'b0;
    logic [7:0] reg_ptr;
    logic [7:0] wr_data;
    logic [7:0] rd_byte;
    logic [7:0] rd_data;
    logic       wr_valid;
    logic       tgt_busy;
    logic       done;
    logic       ack;
    logic       ctl_busy;
    logic [8:0] sh;
    logic [8:0] frame;
    int         bitn      = 0;
    int         err_total = 0;
    int         cmp_count = 0;
    logic [15:0] wr_log[$];
    row_type    rows [0:6] = '{
        '{STRAP_GND, 8'h60, 1'b1}, '{STRAP_VCC, 8'h66, 1'b1},
        '{STRAP_CLK, 8'h62, 1'b1}, '{STRAP_DATA, 8'h64, 1'b1},
        '{STRAP_GND, 8'h66, 1'b0}, '{STRAP_CLK, 8'h64, 1'b0},
        '{STRAP_VCC, 8'he6, 1'b0}};

    always #5 ref_clk_i = ~ref_clk_i;
    // Register file model: each location reads back as its index mixed.
    assign rd_data = reg_ptr ^ 8'h5a;

    led_i2c_if bus_if ();
    led_i2c_target led_i2c_target_i (.ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i), .bus(bus_if), .strap_i(strap),
        .rd_data_i(rd_data), .reg_ptr_o(reg_ptr), .wr_data_o(wr_data),
        .wr_valid_o(wr_valid), .busy_o(tgt_busy));
    led_i2c_controller #(.HALF_CYC(60)) led_i2c_controller_i (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .bus(bus_if),
        .req_i(req), .req_byte_i(req_byte), .req_start_i(req_start),
        .req_stop_i(req_stop), .req_read_i(req_read), .req_nack_i(req_nack),
        .done_o(done), .ack_o(ack), .rd_byte_o(rd_byte), .busy_o(ctl_busy));
    led_i2c_props #(.MIN_HALF(50)) led_i2c_props_i (.ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i), .scl(bus_if.scl), .scl_o(bus_if.scl_o),
        .sda(bus_if.sda), .sda_ctl_o(bus_if.sda_ctl_o),
        .sda_ctl_oe(bus_if.sda_ctl_oe), .sda_tgt_o(bus_if.sda_tgt_o),
        .sda_tgt_oe(bus_if.sda_tgt_oe));

    // Wire sniffer: a start clears the count, nine clock rises make a frame.
    always @(negedge bus_if.sda) if (bus_if.scl) bitn = 0;
    always @(posedge bus_if.scl) begin
        sh = {sh[7:0], bus_if.sda};
        bitn++;
        if (bitn == 9) begin
            frame = sh;
            bitn  = 0;
        end
    end
    always @(negedge ref_clk_i) begin
        if (wr_valid === 1'b1) wr_log.push_back({reg_ptr, wr_data});
    end

    task automatic chk1(input string nm, input logic e, input logic g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %b seen %b", nm, e, g);
        end
    endtask

    task automatic chk8(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic summarize;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic xfer(input logic [7:0] b, input logic st, input logic sp,
                        input logic rd, input logic nk);
        int n;
        n = 0;
        while (ctl_busy !== 1'b0 && n < 4000) begin
            @(negedge ref_clk_i);
            n++;
        end
        @(posedge ref_clk_i);
        req <= 1'b1;
        req_byte <= b;
        req_start <= st;
        req_stop <= sp;
        req_read <= rd;
        req_nack <= nk;
        @(posedge ref_clk_i);
        req <= 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 4000) begin
            @(negedge ref_clk_i);
            n++;
        end
        if (n >= 4000) begin
            err_total++;
            $display("ERROR done expected 1 seen timeout");
        end
    endtask

    initial begin
        repeat (80000) @(posedge ref_clk_i);
        err_total++;
        $display("ERROR watchdog expected finish seen hang");
        summarize();
    end

    initial begin
        repeat (20) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        repeat (5) @(negedge ref_clk_i);
        chk8("reg_ptr", 8'h00, reg_ptr);
        chk1("sda idle", 1'b1, bus_if.sda);
        chk1("tgt busy", 1'b0, tgt_busy);
        $display("test reset done");
        foreach (rows[i]) begin
            @(posedge ref_clk_i);
            strap <= rows[i].strap;
            xfer(rows[i].addr, 1'b1, 1'b1, 1'b0, 1'b0);
            chk1("addr ack", rows[i].ack, ack);
            chk8("frame byte", rows[i].addr, frame[8:1]);
            chk1("frame ack", !rows[i].ack, frame[0]);
            chk1("sda after stop", 1'b1, bus_if.sda);
            chk1("busy after stop", 1'b0, tgt_busy);
            $display("test row %0d done", i);
        end
        @(posedge ref_clk_i);
        strap <= STRAP_GND;
        xfer(8'h60, 1'b1, 1'b0, 1'b0, 1'b0);
        chk1("busy in transfer", 1'b1, tgt_busy);
        xfer(8'h10, 1'b0, 1'b0, 1'b0, 1'b0);
        chk1("pointer ack", 1'b1, ack);
        xfer(8'ha1, 1'b0, 1'b0, 1'b0, 1'b0);
        chk1("data ack", 1'b1, ack);
        xfer(8'hb2, 1'b0, 1'b1, 1'b0, 1'b0);
        chk1("data ack", 1'b1, ack);
        chk8("frame byte", 8'hb2, frame[8:1]);
        chk8("writes", 8'd2, 8'(wr_log.size()));
        chk8("wr ptr 0", 8'h10, wr_log[0][15:8]);
        chk8("wr data 0", 8'ha1, wr_log[0][7:0]);
        chk8("wr ptr 1", 8'h11, wr_log[1][15:8]);
        chk8("wr data 1", 8'hb2, wr_log[1][7:0]);
        chk8("reg_ptr", 8'h12, reg_ptr);
        $display("test write done");
        xfer(8'h60, 1'b1, 1'b0, 1'b0, 1'b0);
        xfer(8'h30, 1'b0, 1'b0, 1'b0, 1'b0);
        xfer(8'h61, 1'b1, 1'b0, 1'b0, 1'b0);
        chk1("read addr ack", 1'b1, ack);
        xfer(8'h00, 1'b0, 1'b0, 1'b1, 1'b0);
        chk8("read byte 0", 8'h30 ^ 8'h5a, rd_byte);
        xfer(8'h00, 1'b0, 1'b1, 1'b1, 1'b1);
        chk8("read byte 1", 8'h31 ^ 8'h5a, rd_byte);
        chk1("sda after nack", 1'b1, bus_if.sda);
        chk1("busy after read", 1'b0, tgt_busy);
        $display("test read done");
        wr_log.delete();
        xfer(8'h66, 1'b1, 1'b0, 1'b0, 1'b0);
        chk1("foreign ack", 1'b0, ack);
        chk1("stop on nack", 1'b1, bus_if.sda);
        chk1("idle on nack", 1'b0, tgt_busy);
        xfer(8'h6e, 1'b1, 1'b0, 1'b0, 1'b0);
        chk1("ignored ack", 1'b0, ack);
        xfer(8'he0, 1'b1, 1'b1, 1'b0, 1'b0);
        chk1("ignored ack", 1'b0, ack);
        chk8("ignored writes", 8'd0, 8'(wr_log.size()));
        $display("test mismatch done");
        xfer(8'h60, 1'b1, 1'b0, 1'b0, 1'b0);
        xfer(8'h44, 1'b0, 1'b0, 1'b0, 1'b0);
        xfer(8'h55, 1'b0, 1'b0, 1'b0, 1'b0);
        chk8("reg_ptr", 8'h45, reg_ptr);
        @(posedge ref_clk_i);
        reset_n_i <= 1'b0;
        repeat (3) @(negedge ref_clk_i);
        chk8("reset ptr", 8'h00, reg_ptr);
        chk1("reset oe", 1'b0, bus_if.sda_tgt_oe);
        chk1("reset busy", 1'b0, tgt_busy);
        @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        repeat (5) @(posedge ref_clk_i);
        xfer(8'h60, 1'b1, 1'b1, 1'b0, 1'b0);
        chk1("ack after reset", 1'b1, ack);
        $display("test mid reset done");
        summarize();
    end
endmodule // tb_top
